// ### hw/rra_pkg.sv
// Constants and types shared by the remote read arbiter
package rra_pkg;
	localparam int         AXI_AW       = 5;
	localparam logic [4:0] OFF_RIC      = 5'h00;
	localparam logic [4:0] OFF_DCR      = 5'h04;
	localparam logic [4:0] OFF_PC       = 5'h08;
	localparam logic [4:0] OFF_STAT     = 5'h0c;
	localparam int         RIC_MS_LSB   = 0;
	localparam int         RIC_LAT_BIT  = 2;
	localparam int         DCR_IW_LSB   = 0;
	localparam int         DCR_DW_LSB   = 2;
	localparam int         DCR_LOR_BIT  = 5;
	localparam logic [1:0] MS_DATA_MEMORY      = 2'h0;
	localparam logic [1:0] MS_INSTRUCTION_MEMORY      = 2'h1;
	localparam logic [1:0] MS_PC_LO     = 2'h2;
	localparam logic [1:0] MS_PC_HI     = 2'h3;
	localparam logic [7:0] RIC_RST      = 8'h00;
	localparam logic [7:0] DCR_RST      = 8'h00;
	localparam logic [15:0] PC_RST      = 16'h0000;
	localparam logic [1:0] RESP_OK      = 2'h0;
	localparam logic [1:0] RESP_ERR     = 2'h2;
	localparam int         SYNC_W       = 5;
	localparam int         SY_ENA       = 0;
	localparam int         SY_RD        = 1;
	localparam int         SY_CMD       = 2;
	localparam int         SY_WAIT      = 3;
	localparam int         SY_LOCK      = 4;

	typedef enum logic [3:0] {
		ST_IDLE, ST_ARB_WAIT, ST_TAKEOVER, ST_ACC_START, ST_ACCESS, ST_HOLD,
		ST_REL_FIRST, ST_REL_SECOND, ST_RECOVER, ST_LAT_REL, ST_LAT_WAIT
	} rra_state_t;

	typedef enum logic [2:0] {
		TG_CFG, TG_PC_LO, TG_PC_HI, TG_DATA_MEMORY, TG_INSTRUCTION_MEMORY_LO, TG_INSTRUCTION_MEMORY_HI
	} rra_tgt_t;
endpackage : rra_pkg

// ### hw/rra_remote_read_arbiter.sv
// Remote read arbitration state machine with AXI4-Lite registers
`timescale 1ns/1ns
module rra_remote_read_arbiter
	import rra_pkg::*;
(
	input  wire logic              SYS_CLK_IN,
	input  wire logic              SYS_RST_IN,
	input  wire logic [AXI_AW-1:0] S_AXI_AWADDR_IN,
	input  wire logic              S_AXI_AWVALID_IN,
	output logic                   S_AXI_AWREADY_OUT,
	input  wire logic [31:0]       S_AXI_WDATA_IN,
	input  wire logic [3:0]        S_AXI_WSTRB_IN,
	input  wire logic              S_AXI_WVALID_IN,
	output logic                   S_AXI_WREADY_OUT,
	output logic [1:0]             S_AXI_BRESP_OUT,
	output logic                   S_AXI_BVALID_OUT,
	input  wire logic              S_AXI_BREADY_IN,
	input  wire logic [AXI_AW-1:0] S_AXI_ARADDR_IN,
	input  wire logic              S_AXI_ARVALID_IN,
	output logic                   S_AXI_ARREADY_OUT,
	output logic [31:0]            S_AXI_RDATA_OUT,
	output logic [1:0]             S_AXI_RRESP_OUT,
	output logic                   S_AXI_RVALID_OUT,
	input  wire logic              S_AXI_RREADY_IN,
	input  wire logic              REMOTE_ACCESS_ENABLE_N_IN,
	input  wire logic              REMOTE_READ_STROBE_N_IN,
	input  wire logic              REG_SELECT_IN,
	input  wire logic              WAIT_N_IN,
	input  wire logic              LOCK_N_IN,
	input  wire logic              LOCAL_BUS_REQUEST_IN,
	input  wire logic [15:0]       INSTR_WORD_IN,
	input  wire logic [7:0]        DATA_ADDR_HI_IN,
	output logic                   LOCAL_BUS_GRANT_OUT,
	output logic                   REMOTE_STALL_TSTATE_OUT,
	output logic                   TRANSFER_ACKNOWLEDGE_OUT,
	output logic                   LOCAL_OWNER_OUTPUT_OUT,
	output logic                   MEM_READ_N_OUT,
	output logic [7:0]             ADDR_OUT,
	output logic                   ADDR_OE_OUT,
	output logic [7:0]             AD_OUT,
	output logic                   AD_OE_OUT,
	output logic [15:0]            PC_OUT,
	output logic                   HIGH_BYTE_EXPECTED_FLAG_OUT
);

	function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				res[i*8 +: 8] = new_v[i*8 +: 8];
		end
		return res;
	endfunction : merge_strb

	function automatic logic is_free(input rra_state_t s);
		return (s == ST_IDLE) || (s == ST_ARB_WAIT) || (s == ST_LAT_REL) || (s == ST_LAT_WAIT);
	endfunction : is_free

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic [SYNC_W-1:0] sync1_reg;
	logic [SYNC_W-1:0] sync2_reg;

	always_ff @(posedge SYS_CLK_IN)
	begin
		if (SYS_RST_IN)
		begin
			sync1_reg <= 5'h1b;
			sync2_reg <= 5'h1b;
		end
		else
		begin
			sync1_reg <= {LOCK_N_IN, WAIT_N_IN, REG_SELECT_IN,
				REMOTE_READ_STROBE_N_IN, REMOTE_ACCESS_ENABLE_N_IN};
			sync2_reg <= sync1_reg;
		end
	end

	logic req;
	logic cmd_hi;
	logic wait_hi;
	logic lock_hi;
	assign req     = !sync2_reg[SY_ENA] && !sync2_reg[SY_RD];
	assign cmd_hi  = sync2_reg[SY_CMD];
	assign wait_hi = sync2_reg[SY_WAIT];
	assign lock_hi = sync2_reg[SY_LOCK];

	////////////////////////////////////////////////////////////////////////////////
	// Registers and AXI4-Lite slave

	logic [7:0]        ric_reg;
	logic [7:0]        dcr_reg;
	logic [15:0]       pc_reg;
	logic              hib_reg;
	logic [AXI_AW-1:0] waddr_reg;
	logic [31:0]       wdata_reg;
	logic [3:0]        wstrb_reg;
	logic              aw_full_reg;
	logic              w_full_reg;
	rra_state_t        state_reg;
	rra_state_t        state_next;
	rra_tgt_t          tgt_reg;
	rra_tgt_t          tgt_next;
	logic [2:0]        cnt_reg;
	logic              lat_reg;
	logic              lat_next;
	logic              grant_reg;
	logic              grant_next;

	logic wr_fire;
	logic lockout;
	assign wr_fire = aw_full_reg && w_full_reg && !S_AXI_BVALID_OUT;
	assign lockout = dcr_reg[DCR_LOR_BIT];

	always_ff @(posedge SYS_CLK_IN)
	begin
		if (SYS_RST_IN)
		begin
			S_AXI_AWREADY_OUT <= 1'b1;
			S_AXI_WREADY_OUT  <= 1'b1;
			S_AXI_BVALID_OUT  <= 1'b0;
			S_AXI_BRESP_OUT   <= RESP_OK;
			aw_full_reg       <= 1'b0;
			w_full_reg        <= 1'b0;
			waddr_reg         <= '0;
			wdata_reg         <= '0;
			wstrb_reg         <= 4'h0;
		end
		else
		begin
			if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT)
			begin
				waddr_reg         <= S_AXI_AWADDR_IN;
				aw_full_reg       <= 1'b1;
				S_AXI_AWREADY_OUT <= 1'b0;
			end
			if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT)
			begin
				wdata_reg        <= S_AXI_WDATA_IN;
				wstrb_reg        <= S_AXI_WSTRB_IN;
				w_full_reg       <= 1'b1;
				S_AXI_WREADY_OUT <= 1'b0;
			end
			if (wr_fire)
			begin
				aw_full_reg      <= 1'b0;
				w_full_reg       <= 1'b0;
				S_AXI_BVALID_OUT <= 1'b1;
				S_AXI_BRESP_OUT  <= (waddr_reg > OFF_STAT) ? RESP_ERR : RESP_OK;
			end
			if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN)
			begin
				S_AXI_BVALID_OUT  <= 1'b0;
				S_AXI_AWREADY_OUT <= 1'b1;
				S_AXI_WREADY_OUT  <= 1'b1;
			end
		end
	end

	always_ff @(posedge SYS_CLK_IN)
	begin
		if (SYS_RST_IN)
		begin
			S_AXI_ARREADY_OUT <= 1'b1;
			S_AXI_RVALID_OUT  <= 1'b0;
			S_AXI_RDATA_OUT   <= 32'h0;
			S_AXI_RRESP_OUT   <= RESP_OK;
		end
		else if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT)
		begin
			S_AXI_ARREADY_OUT <= 1'b0;
			S_AXI_RVALID_OUT  <= 1'b1;
			S_AXI_RRESP_OUT   <= RESP_OK;
			case ({S_AXI_ARADDR_IN[AXI_AW-1:2], 2'b00})
				OFF_RIC:  S_AXI_RDATA_OUT <= {24'h0, ric_reg};
				OFF_DCR:  S_AXI_RDATA_OUT <= {24'h0, dcr_reg};
				OFF_PC:   S_AXI_RDATA_OUT <= {16'h0, pc_reg};
				OFF_STAT: S_AXI_RDATA_OUT <= {24'h0, grant_reg, TRANSFER_ACKNOWLEDGE_OUT,
					LOCAL_OWNER_OUTPUT_OUT, hib_reg, state_reg};
				default:
				begin
					S_AXI_RDATA_OUT <= 32'h0;
					S_AXI_RRESP_OUT <= RESP_ERR;
				end
			endcase
		end
		else if (S_AXI_RVALID_OUT && S_AXI_RREADY_IN)
		begin
			S_AXI_RVALID_OUT  <= 1'b0;
			S_AXI_ARREADY_OUT <= 1'b1;
		end
	end

	logic wr_ric;
	logic wr_dcr;
	logic wr_pc;
	logic [31:0] ric_new;
	logic [31:0] dcr_new;
	logic [31:0] pc_new;
	assign wr_ric  = wr_fire && ({waddr_reg[AXI_AW-1:2], 2'b00} == OFF_RIC);
	assign wr_dcr  = wr_fire && ({waddr_reg[AXI_AW-1:2], 2'b00} == OFF_DCR);
	assign wr_pc   = wr_fire && ({waddr_reg[AXI_AW-1:2], 2'b00} == OFF_PC);
	assign ric_new = merge_strb({24'h0, ric_reg}, wdata_reg, wstrb_reg);
	assign dcr_new = merge_strb({24'h0, dcr_reg}, wdata_reg, wstrb_reg);
	assign pc_new  = merge_strb({16'h0, pc_reg}, wdata_reg, wstrb_reg);

	always_ff @(posedge SYS_CLK_IN)
	begin
		if (SYS_RST_IN)
		begin
			ric_reg <= RIC_RST;
			dcr_reg <= DCR_RST;
		end
		else
		begin
			if (wr_ric)
				ric_reg <= ric_new[7:0];
			if (wr_dcr)
				dcr_reg <= dcr_new[7:0];
		end
	end

	logic rel_instruction_memory;
	assign rel_instruction_memory = ((state_reg == ST_REL_FIRST) || (state_reg == ST_LAT_REL))
		&& ((tgt_reg == TG_INSTRUCTION_MEMORY_LO) || (tgt_reg == TG_INSTRUCTION_MEMORY_HI));

	// Hardware toggle beats a same-cycle software clear
	always_ff @(posedge SYS_CLK_IN)
	begin
		if (SYS_RST_IN)
			hib_reg <= 1'b0;
		else if (rel_instruction_memory)
			hib_reg <= !hib_reg;
		else if (wr_ric && wstrb_reg[0] && ric_new[RIC_MS_LSB +: 2] == MS_INSTRUCTION_MEMORY)
			hib_reg <= 1'b0;
	end

	always_ff @(posedge SYS_CLK_IN)
	begin
		if (SYS_RST_IN)
			pc_reg <= PC_RST;
		else if (rel_instruction_memory && tgt_reg == TG_INSTRUCTION_MEMORY_HI)
			pc_reg <= pc_reg + 16'h0001;
		else if (wr_pc)
			pc_reg <= pc_new[15:0];
	end

	////////////////////////////////////////////////////////////////////////////////
	// Arbitration state machine

	logic go;
	assign go = !lockout && !grant_reg && !(LOCAL_BUS_REQUEST_IN && lock_hi);

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE:
				if (req)
					state_next = go ? ST_TAKEOVER : ST_ARB_WAIT;
			ST_ARB_WAIT:
				if (!req)
					state_next = ST_IDLE;
				else if (go)
					state_next = ST_TAKEOVER;
			ST_TAKEOVER:
				state_next = ST_ACC_START;
			ST_ACC_START:
				state_next = ST_ACCESS;
			ST_ACCESS:
				if (cnt_reg == 3'h0 && wait_hi)
					state_next = ST_HOLD;
			ST_HOLD:
				if (lat_reg)
					state_next = ST_LAT_REL;
				else if (!req)
					state_next = (tgt_reg == TG_DATA_MEMORY) ? ST_REL_SECOND : ST_REL_FIRST;
			ST_REL_FIRST:
				state_next = ST_IDLE;
			ST_REL_SECOND:
				state_next = ST_RECOVER;
			ST_RECOVER:
				state_next = (req && go) ? ST_TAKEOVER : ST_IDLE;
			ST_LAT_REL:
				state_next = req ? ST_LAT_WAIT : ST_IDLE;
			ST_LAT_WAIT:
				if (!req)
					state_next = ST_IDLE;
			default:
				state_next = ST_IDLE;
		endcase
	end

	always_comb
	begin
		tgt_next = tgt_reg;
		lat_next = lat_reg;
		if (state_reg == ST_ACC_START)
		begin
			lat_next = ric_reg[RIC_LAT_BIT];
			if (cmd_hi)
				tgt_next = TG_CFG;
			else
			begin
				case (ric_reg[RIC_MS_LSB +: 2])
					MS_DATA_MEMORY:  tgt_next = TG_DATA_MEMORY;
					MS_INSTRUCTION_MEMORY:  tgt_next = hib_reg ? TG_INSTRUCTION_MEMORY_HI : TG_INSTRUCTION_MEMORY_LO;
					MS_PC_LO: tgt_next = TG_PC_LO;
					default:  tgt_next = TG_PC_HI;
				endcase
			end
		end
	end

	always_ff @(posedge SYS_CLK_IN)
	begin
		if (SYS_RST_IN)
		begin
			state_reg <= ST_IDLE;
			tgt_reg   <= TG_CFG;
			lat_reg   <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			tgt_reg   <= tgt_next;
			lat_reg   <= lat_next;
		end
	end

	// Only memory targets carry programmed waits
	always_ff @(posedge SYS_CLK_IN)
	begin
		if (SYS_RST_IN)
			cnt_reg <= 3'h0;
		else if (state_reg == ST_ACC_START)
		begin
			if (tgt_next == TG_DATA_MEMORY)
				cnt_reg <= dcr_reg[DCR_DW_LSB +: 3];
			else if (tgt_next == TG_INSTRUCTION_MEMORY_LO || tgt_next == TG_INSTRUCTION_MEMORY_HI)
				cnt_reg <= {1'b0, dcr_reg[DCR_IW_LSB +: 2]};
			else
				cnt_reg <= 3'h0;
		end
		else if (state_reg == ST_ACCESS && cnt_reg != 3'h0)
			cnt_reg <= cnt_reg - 3'h1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registered pin outputs, computed from the next state except grant, stall and ADDR_OUT

	logic busy_next;
	logic data_memory_next;
	logic data_memory_pend;
	logic drive_next;
	assign data_memory_pend = !cmd_hi && (ric_reg[RIC_MS_LSB +: 2] == MS_DATA_MEMORY);
	assign busy_next = !is_free(state_next) && (state_next != ST_IDLE || 1'b0);
	assign data_memory_next = (state_next == ST_TAKEOVER || state_next == ST_ACC_START) ?
		data_memory_pend : (tgt_next == TG_DATA_MEMORY);
	assign drive_next = (state_next == ST_ACCESS) || (state_next == ST_HOLD);
	assign grant_next = LOCAL_BUS_REQUEST_IN && lock_hi && (grant_reg || is_free(state_reg));

	always_ff @(posedge SYS_CLK_IN)
	begin
		if (SYS_RST_IN)
		begin
			LOCAL_BUS_GRANT_OUT      <= 1'b0;
			grant_reg                <= 1'b0;
			REMOTE_STALL_TSTATE_OUT  <= 1'b0;
			TRANSFER_ACKNOWLEDGE_OUT <= 1'b1;
			LOCAL_OWNER_OUTPUT_OUT   <= 1'b0;
			MEM_READ_N_OUT           <= 1'b1;
			ADDR_OE_OUT              <= 1'b1;
			AD_OE_OUT                <= 1'b1;
			ADDR_OUT                 <= 8'h00;
			AD_OUT                   <= 8'h00;
		end
		else
		begin
			grant_reg                <= grant_next;
			LOCAL_BUS_GRANT_OUT      <= grant_next;
			REMOTE_STALL_TSTATE_OUT  <= LOCAL_BUS_REQUEST_IN && !grant_next;
			TRANSFER_ACKNOWLEDGE_OUT <= !((state_next == ST_TAKEOVER) || (state_next == ST_ACC_START)
				|| (state_next == ST_ACCESS) || (state_next == ST_ARB_WAIT && req));
			LOCAL_OWNER_OUTPUT_OUT   <= (state_next == ST_ACC_START) || (state_next == ST_ACCESS)
				|| (state_next == ST_REL_SECOND)
				|| (state_next == ST_HOLD && (lat_next || tgt_next == TG_DATA_MEMORY || req));
			MEM_READ_N_OUT           <= !(tgt_next == TG_DATA_MEMORY && ((state_next == ST_ACCESS)
				|| (state_next == ST_HOLD && (req || lat_next))));
			ADDR_OE_OUT              <= !busy_next;
			AD_OE_OUT                <= !(busy_next && data_memory_next);
			ADDR_OUT                 <= DATA_ADDR_HI_IN;
			if (drive_next && tgt_next == TG_PC_LO)
				AD_OUT <= pc_reg[7:0];
			else if (drive_next && tgt_next == TG_PC_HI)
				AD_OUT <= pc_reg[15:8];
			else if (drive_next && tgt_next == TG_INSTRUCTION_MEMORY_LO)
				AD_OUT <= INSTR_WORD_IN[7:0];
			else if (drive_next && tgt_next == TG_INSTRUCTION_MEMORY_HI)
				AD_OUT <= INSTR_WORD_IN[15:8];
			else
				AD_OUT <= ric_reg;
		end
	end

	assign PC_OUT                      = pc_reg;
	assign HIGH_BYTE_EXPECTED_FLAG_OUT = hib_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking @(posedge SYS_CLK_IN); endclocking
	default disable iff (SYS_RST_IN);

	a_wait_extends:
	assert property (state_reg == ST_ACCESS && cnt_reg == 3'h0 && !wait_hi |=> state_reg == ST_ACCESS)
		else $error("wait input did not stretch access");
	a_access_to_hold:
	assert property (state_reg == ST_ACCESS && cnt_reg == 3'h0 && wait_hi |=> state_reg == ST_HOLD)
		else $error("access did not advance to hold");
	a_hold_outputs:
	assert property (state_reg == ST_HOLD && tgt_reg == TG_DATA_MEMORY
		|-> LOCAL_OWNER_OUTPUT_OUT && TRANSFER_ACKNOWLEDGE_OUT && !ADDR_OE_OUT && !AD_OE_OUT)
		else $error("hold state outputs wrong");
	a_second_release:
	assert property (state_reg == ST_HOLD && tgt_reg == TG_DATA_MEMORY && !lat_reg && !req
		|=> state_reg == ST_REL_SECOND && LOCAL_OWNER_OUTPUT_OUT && !AD_OE_OUT)
		else $error("data hold did not enter second release");
	a_owner_falls:
	assert property (state_reg == ST_HOLD && tgt_reg != TG_DATA_MEMORY && !lat_reg && !req
		|=> !LOCAL_OWNER_OUTPUT_OUT)
		else $error("owner stayed high after strobe release");
	a_flag_toggles:
	assert property (rel_instruction_memory |=> hib_reg != $past(hib_reg))
		else $error("instruction flag did not toggle");
	a_pc_bumps:
	assert property (rel_instruction_memory && tgt_reg == TG_INSTRUCTION_MEMORY_HI && !wr_pc |=> pc_reg == $past(pc_reg) + 16'h0001)
		else $error("program counter not incremented");
	a_recovery_path:
	assert property (state_reg == ST_REL_SECOND
		|=> state_reg == ST_RECOVER && !LOCAL_OWNER_OUTPUT_OUT && !AD_OE_OUT)
		else $error("second release did not recover");
	a_owner_delay:
	assert property (state_reg == ST_TAKEOVER |-> !LOCAL_OWNER_OUTPUT_OUT ##1 LOCAL_OWNER_OUTPUT_OUT)
		else $error("owner output not delayed one state");
	a_latched_end:
	assert property (state_reg == ST_HOLD && lat_reg |=> state_reg == ST_LAT_REL)
		else $error("latched read waited for host");
	a_lockout_wait:
	assert property (state_reg == ST_ARB_WAIT && lockout && req
		|=> state_reg == ST_ARB_WAIT && !TRANSFER_ACKNOWLEDGE_OUT)
		else $error("lockout did not hold off access");
	a_grant_free:
	assert property (grant_reg |-> is_free(state_reg))
		else $error("local grant while buses in use");
	a_ack_drops:
	assert property (state_reg == ST_IDLE && req |=> !TRANSFER_ACKNOWLEDGE_OUT)
		else $error("acknowledge did not drop on request");
	a_data_memory_strobe:
	assert property (state_reg == ST_ACCESS && tgt_reg == TG_DATA_MEMORY |-> !MEM_READ_N_OUT && !AD_OE_OUT)
		else $error("data read strobe or float missing");
	a_latched_strobe:
	assert property (state_reg == ST_HOLD && lat_reg && tgt_reg == TG_DATA_MEMORY
		|-> !MEM_READ_N_OUT ##1 MEM_READ_N_OUT && !LOCAL_OWNER_OUTPUT_OUT)
		else $error("latched strobe or owner release wrong");

endmodule : rra_remote_read_arbiter

// ### dv/rra_remote_host.sv
// Remote host model that drives the read strobe pins of the arbiter
`timescale 1ns/1ns
module rra_remote_host
(
	input  wire logic       clk_in,
	input  wire logic       go_in,
	input  wire logic       sel_in,
	input  wire logic [7:0] hold_in,
	input  wire logic [7:0] wait_in,
	input  wire logic       ack_in,
	input  wire logic [7:0] ad_in,
	input  wire logic       ad_oe_in,
	output logic            ena_n_out,
	output logic            rd_n_out,
	output logic            sel_out,
	output logic            wait_n_out,
	output logic            busy_out,
	output logic            hit_out,
	output logic [7:0]      lat_out,
	output logic [7:0]      ad_out,
	output logic            oe_out
);
	int   n;
	logic low_seen;
	initial
	begin
		{ena_n_out, rd_n_out, wait_n_out} = 3'b111;
		{sel_out, busy_out, hit_out, oe_out} = 4'h0;
		{lat_out, ad_out} = 16'h0000;
		forever
		begin
			@(posedge clk_in);
			if (!go_in)
				sel_out <= ~sel_out; // Idle select line never shows a stale level
			else
			begin
				busy_out <= 1'b1;
				{ena_n_out, rd_n_out} <= 2'b00;
				sel_out <= sel_in;
				wait_n_out <= (wait_in == 8'h00);
				n = 0;
				low_seen = 1'b0;
				// Bounded so a stuck acknowledge shows up as a long latency
				while (n < 250 && !(low_seen && ack_in))
				begin
					@(posedge clk_in);
					n++;
					if (n == int'(wait_in))
						wait_n_out <= 1'b1;
					if (!ack_in)
						low_seen = 1'b1;
				end
				lat_out <= 8'(n);
				ad_out <= ad_in;
				oe_out <= ad_oe_in;
				hit_out <= 1'b1;
				repeat (int'(hold_in)) @(posedge clk_in);
				{ena_n_out, rd_n_out, hit_out} <= 3'b110;
				while (go_in) @(posedge clk_in);
				busy_out <= 1'b0;
			end
		end
	end
endmodule : rra_remote_host

// ### dv/remote_read_arbiter_test.sv
// Self-checking bench for the remote read arbiter
`timescale 1ns/1ns
module remote_read_arbiter_test
	import rra_pkg::*;
;
	typedef struct packed {
		logic sel; logic [7:0] remote_interface_config; logic wr; logic [7:0] ad; logic oe; logic [15:0] pc; logic flag;
	} rra_row_t;
	logic              clk, rst, go, hsel, lock_n, lreq;
	logic [AXI_AW-1:0] awaddr, araddr;
	logic              awvalid, wvalid, bready, arvalid, rready;
	logic [31:0]       wdata, rdata, rd;
	logic              awready, wready, bvalid, arready, rvalid;
	logic [1:0]        bresp, rresp, resp;
	logic              ena_n, rd_n, sel, wait_n, busy, hit, hoe;
	logic [7:0]        hold, wcyc, lat, had, base, addr, ad;
	logic              grant, stall, ack, owner, read_n, addr_oe, ad_oe, flag;
	logic [15:0]       pc;
	int                error_cnt, check_count, i, k;
	rra_row_t          rows [6];

	rra_remote_read_arbiter dut_u
	(
		.SYS_CLK_IN(clk), .SYS_RST_IN(rst),
		.S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
		.S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(4'hf), .S_AXI_WVALID_IN(wvalid),
		.S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
		.S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
		.S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
		.S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready),
		.REMOTE_ACCESS_ENABLE_N_IN(ena_n), .REMOTE_READ_STROBE_N_IN(rd_n),
		.REG_SELECT_IN(sel), .WAIT_N_IN(wait_n), .LOCK_N_IN(lock_n),
		.LOCAL_BUS_REQUEST_IN(lreq), .INSTR_WORD_IN(16'hbeef), .DATA_ADDR_HI_IN(8'h5a),
		.LOCAL_BUS_GRANT_OUT(grant), .REMOTE_STALL_TSTATE_OUT(stall),
		.TRANSFER_ACKNOWLEDGE_OUT(ack), .LOCAL_OWNER_OUTPUT_OUT(owner),
		.MEM_READ_N_OUT(read_n), .ADDR_OUT(addr), .ADDR_OE_OUT(addr_oe), .AD_OUT(ad),
		.AD_OE_OUT(ad_oe), .PC_OUT(pc), .HIGH_BYTE_EXPECTED_FLAG_OUT(flag)
	);

	rra_remote_host host_u
	(
		.clk_in(clk), .go_in(go), .sel_in(hsel), .hold_in(hold), .wait_in(wcyc),
		.ack_in(ack), .ad_in(ad), .ad_oe_in(ad_oe), .ena_n_out(ena_n), .rd_n_out(rd_n),
		.sel_out(sel), .wait_n_out(wait_n), .busy_out(busy), .hit_out(hit),
		.lat_out(lat), .ad_out(had), .oe_out(hoe)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic conclude();
		$display("mismatches %0d comparisons %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : conclude

	task automatic axi_wr(input logic [AXI_AW-1:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_t, w_t;
		@(posedge clk);
		{aw_t, w_t} = 2'b00;
		awaddr <= a;
		wdata <= d;
		{awvalid, wvalid, bready} <= 3'b111;
		for (int j = 0; j < 50; j++)
		begin
			@(posedge clk);
			if (aw_t && w_t && bvalid)
				break;
			if (!aw_t && awready)
			begin
				aw_t = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_t && wready)
			begin
				w_t = 1'b1;
				wvalid <= 1'b0;
			end
		end
		check("bvalid seen", bvalid, 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [AXI_AW-1:0] a, output logic [31:0] d, output logic [1:0] r);
		logic a_t;
		@(posedge clk);
		a_t = 1'b0;
		araddr <= a;
		{arvalid, rready} <= 2'b11;
		for (int j = 0; j < 50; j++)
		begin
			@(posedge clk);
			if (a_t && rvalid)
				break;
			if (!a_t && arready)
			begin
				a_t = 1'b1;
				arvalid <= 1'b0;
			end
		end
		check("rvalid seen", rvalid, 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : axi_rd

	task automatic host_go(input logic s, input logic [7:0] h, input logic [7:0] w);
		@(posedge clk);
		{hsel, hold, wcyc} <= {s, h, w};
		go <= 1'b1;
	endtask : host_go

	task automatic wait_hit();
		for (int j = 0; j < 400 && !hit; j++) @(posedge clk);
		check("host answered", hit, 1'b1);
	endtask : wait_hit

	// Eight idle cycles let the machine settle back to idle
	task automatic host_end();
		@(posedge clk);
		go <= 1'b0;
		for (int j = 0; j < 400 && busy; j++) @(posedge clk);
		check("host released", busy, 1'b0);
		repeat (8) @(posedge clk);
	endtask : host_end

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	initial
	begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		conclude();
	end

	initial
	begin
		{rst, lock_n, lreq, go, hsel, awvalid, wvalid, bready, arvalid, rready} = 10'b1100000000;
		{awaddr, araddr, wdata, hold, wcyc} = '0;
		{error_cnt, check_count} = 0;
		rows[0] = '{1'b1, 8'h08, 1'b1, 8'h08, 1'b1, 16'h1234, 1'b0};
		rows[1] = '{1'b0, 8'h02, 1'b1, 8'h34, 1'b1, 16'h1234, 1'b0};
		rows[2] = '{1'b0, 8'h03, 1'b1, 8'h12, 1'b1, 16'h1234, 1'b0};
		rows[3] = '{1'b0, 8'h00, 1'b1, 8'h00, 1'b0, 16'h1234, 1'b0};
		rows[4] = '{1'b0, 8'h01, 1'b1, 8'hef, 1'b1, 16'h1234, 1'b1};
		rows[5] = '{1'b0, 8'h01, 1'b0, 8'hbe, 1'b1, 16'h1235, 1'b0};
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		check("ack", ack, 1'b1);
		check("owner", owner, 1'b0);
		check("read_n", read_n, 1'b1);
		check("flag", flag, 1'b0);
		axi_rd(OFF_RIC, rd, resp);
		check("ric reset", rd, {24'h0, RIC_RST});
		axi_rd(OFF_DCR, rd, resp);
		check("dcr reset", rd, {24'h0, DCR_RST});
		axi_rd(OFF_PC, rd, resp);
		check("pc reset", rd, {16'h0, PC_RST});
		axi_rd(5'h10, rd, resp);
		check("unmapped rresp", resp, RESP_ERR);
		check("unmapped rdata", rd, 32'h0);
		axi_wr(5'h14, 32'hff, resp);
		check("unmapped bresp", resp, RESP_ERR);
		axi_wr(OFF_STAT, 32'hff, resp);
		check("status bresp", resp, RESP_OK);
		axi_wr(OFF_PC, 32'h1234, resp);
		for (i = 0; i < 6; i++)
		begin
			if (rows[i].wr)
				axi_wr(OFF_RIC, {24'h0, rows[i].remote_interface_config}, resp);
			host_go(rows[i].sel, 8'h04, 8'h00);
			wait_hit();
			if (rows[i].oe)
				check("ad byte", had, rows[i].ad);
			check("ad_oe", hoe, rows[i].oe);
			repeat (2) @(posedge clk);
			check("owner hold", owner, 1'b1);
			check("ack hold", ack, 1'b1);
			if (i == 3)
				base = lat;
			host_end();
			check("pc", pc, rows[i].pc);
			check("flag", flag, rows[i].flag);
			check("owner idle", owner, 1'b0);
		end
		check("addr default", addr, 8'h5a);
		check("addr_oe default", addr_oe, 1'b1);
		host_go(1'b0, 8'h02, 8'h00);
		wait_hit();
		host_end();
		check("flag set", flag, 1'b1);
		axi_wr(OFF_RIC, 32'h1, resp);
		check("flag cleared", flag, 1'b0);
		axi_wr(OFF_RIC, 32'h0, resp);
		axi_wr(OFF_DCR, 32'h0c, resp);
		host_go(1'b0, 8'h02, 8'h00);
		wait_hit();
		host_end();
		check("latency dw3", lat, base + 8'h03);
		axi_wr(OFF_DCR, 32'h0, resp);
		host_go(1'b0, 8'h02, 8'h0c);
		wait_hit();
		host_end();
		check("wait stretches", lat > base, 1'b1);
		axi_wr(OFF_DCR, 32'h1c, resp);
		host_go(1'b0, 8'h02, 8'h00);
		for (k = 0; k < 40 && owner !== 1'b1; k++) @(posedge clk);
		check("owner taken", owner, 1'b1);
		lreq <= 1'b1;
		repeat (3) @(posedge clk);
		check("stall", stall, 1'b1);
		check("no grant", grant, 1'b0);
		wait_hit();
		host_end();
		check("grant", grant, 1'b1);
		lock_n <= 1'b0;
		repeat (4) @(posedge clk);
		check("lock blocks grant", grant, 1'b0);
		lock_n <= 1'b1;
		lreq <= 1'b0;
		axi_wr(OFF_DCR, 32'h0, resp);
		axi_wr(OFF_RIC, 32'h04, resp);
		host_go(1'b0, 8'h0c, 8'h00);
		wait_hit();
		repeat (3) @(posedge clk);
		check("latched owner", owner, 1'b0);
		check("latched read_n", read_n, 1'b1);
		check("strobe held", rd_n, 1'b0);
		host_end();
		check("latched ack", ack, 1'b1);
		axi_wr(OFF_RIC, 32'h0, resp);
		axi_wr(OFF_DCR, 32'h20, resp);
		host_go(1'b0, 8'h02, 8'h00);
		repeat (20) @(posedge clk);
		check("lockout ack", ack, 1'b0);
		check("lockout owner", owner, 1'b0);
		axi_wr(OFF_DCR, 32'h0, resp);
		wait_hit();
		host_end();
		conclude();
	end
endmodule : remote_read_arbiter_test
